// ### rtl/pch_config_header.sv
// Notes on behaviour
// - Detected-parity flag sets on master data or target address/data parity errors.
// - Target signals address parity on SERR only with report and parity enables; flag it.
// - Own transactions ending in master-abort or target-abort set their received flags.
// - Target-abort signalled sets its flag; all error flags reset 0, write-one clears.
// - Device select timing reads 01 always and ignores writes.
// - With parity response on, master PERR involvement sets master data parity flag.
// - Capability and speed bits are fixed read-only constants.
// - PERR pulses on data parity errors only when parity response enabled; PAR always.
// - Address parity reaches SERR only when both report and parity enables set.
// - Write-invalidate enable reads 0; DMA command select chooses that command.
// - Master enable resets from strap; memory and I/O enables reset 0, gate decode.
// - Each of the six error flags can raise the external event output.
// - Base class resets 06, subclass 80; both loadable from EEPROM.
// - Programming interface code resets 00.
// - Self-test, multifunction and layout fields read zero.
// - Latency timer keeps bits 7..1 only; reset means eight clocks.
// - Cache line 00 acts as 01; illegal written values read zero.
// - Cache line setting drives burst write and DMA sizing.
// - Register-space base holds bits 31..12, space bit 0; low 12 bits select.
// - Messaging enabled moves register base to 018 and messaging base to 010.
// - Messaging window reserves lowest 4K, maps the rest; base survives reset.
// - Registers reset on PCI reset pin low or board health high.
// - Class fields writable only from local bus and loadable from EEPROM.
module pch_config_header #(
  parameter int MSG_WIN_BITS = 16,
  parameter logic [7:0] REVISION = 8'h5a  // Arbitrary value
) (
  input wire logic core_clk_in,  // 25 MHz clock
  input wire logic reset_in,  // Synchronous reset, active high
  input wire logic pci_rst_n_in,  // PCI reset pin, active low
  input wire logic board_health_input_in,  // High forces reset
  input wire logic initiator_strap_in,  // Power-up master enable option
  input wire pch_pkg::pch_access_t cfg_acc_in,  // PCI configuration access
  input wire pch_pkg::pch_access_t lcl_acc_in,  // Local bus register access
  input wire pch_pkg::pch_events_t events_in,  // One-cycle bus events
  input wire logic eeprom_load_in,  // EEPROM class load strobe
  input wire logic [23:0] eeprom_class_in,  // EEPROM class value
  input wire logic messaging_unit_enable_in,  // Messaging unit on
  input wire logic dma_cmd_select_in,  // DMA command select bit
  input wire logic addr_valid_in,  // PCI address phase valid
  input wire logic [31:0] pci_addr_in,  // PCI address
  input wire logic [35:0] par_data_in,  // AD and C/BE for parity
  output logic cfg_ack_out,  // Config answer pulse
  output logic [31:0] cfg_rdata_out,  // Config read data
  output logic lcl_ack_out,  // Local answer pulse
  output logic [31:0] lcl_rdata_out,  // Local read data
  output logic serr_out,  // SERR assert pulse
  output logic perr_out,  // PERR assert pulse
  output logic par_out,  // Generated parity
  output logic status_event_out,  // Any error flag set
  output logic memory_space_enable_out,  // Memory decode allowed
  output logic io_space_enable_out,  // I/O decode allowed
  output logic initiator_enable_out,  // Master allowed
  output logic mwi_command_out,  // Use write-invalidate
  output logic [3:0] cacheline_words_out,  // Effective line in words
  output logic [6:0] latency_limit_out,  // Latency timer bits 7..1
  output logic reg_space_hit_out,  // Address in register space
  output logic msg_window_hit_out,  // Address in mapped window
  output logic msg_reserved_hit_out  // Address in reserved 4K
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] read_word(input pch_pkg::pch_state_t s,
                                            input logic [11:0] off,
                                            input logic msg_en);
    logic [31:0] r;
    r = 32'h0;
    case (off)
      pch_pkg::OFF_CMD_STATUS: begin
        r[31:27] = s.flags[pch_pkg::FLAG_DPE:pch_pkg::FLAG_STA];
        r[pch_pkg::BIT_MDPED] = s.flags[pch_pkg::FLAG_MDPED];
        r[pch_pkg::BIT_DEVSEL_LO +: 2] = pch_pkg::DEVSEL_MEDIUM;
        r[pch_pkg::BIT_TARGET_BACK_TO_BACK_FLAG] = 1'b1;
        r[pch_pkg::BIT_CAPABILITY_LIST_FLAG] = 1'b1;
        r[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE] = s.system_error_report_enable;
        r[pch_pkg::BIT_PARITY_REACTION_ENABLE] = s.perr_en;
        r[pch_pkg::BIT_BM] = s.bm;
        r[pch_pkg::BIT_MS] = s.ms;
        r[pch_pkg::BIT_IOS] = s.io_space_enable;
      end
      pch_pkg::OFF_CLASS: begin
        r = {s.class_code, REVISION};
      end
      pch_pkg::OFF_MISC: begin
        // Self-test, multifunction and layout stay zero
        r[pch_pkg::LATENCY_LIMIT_LSB +: 7] = s.latency_limit;
        r[pch_pkg::CACHELINE_LENGTH_LSB +: 2] = s.cacheline_length;
      end
      pch_pkg::OFF_BASE_LOW: begin
        r[31:pch_pkg::BASE_LSB] = msg_en ? s.msg_base : s.reg_base;
      end
      pch_pkg::OFF_BASE_ALT: begin
        // Target window 0 base reads zero here unless messaging moves it here from 010
        if (msg_en) begin
          r[31:pch_pkg::BASE_LSB] = s.reg_base;
        end
      end
      default: begin
        r = 32'h0;
      end
    endcase
    return r;
  endfunction : read_word

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pch_pkg::pch_state_t st;
  pch_pkg::pch_state_t next_st;
  pch_pkg::pch_access_t acc [2];
  logic rst;
  logic [pch_pkg::NUM_FLAGS-1:0] set_flags;
  logic [pch_pkg::NUM_FLAGS-1:0] clr_flags;
  logic [31:0] tmp;

  // Pin-driven resets go through the synchroniser before use
  assign rst = reset_in || !st.pci_rst_sync[1] || st.health_sync[1];

  always_comb begin
    next_st = st;
    acc[0] = cfg_acc_in;
    acc[1] = lcl_acc_in;
    set_flags = '0;
    clr_flags = '0;
    tmp = 32'h0;

    next_st.pci_rst_sync = {st.pci_rst_sync[0], pci_rst_n_in};
    next_st.health_sync = {st.health_sync[0], board_health_input_in};
    next_st.strap_sync = {st.strap_sync[0], initiator_strap_in};

    // Event decode, steered by the enables held now
    set_flags[pch_pkg::FLAG_DPE] = events_in.master_data_perr
        || events_in.target_addr_perr || events_in.target_data_perr;
    set_flags[pch_pkg::FLAG_SSERR] = events_in.target_addr_perr
        && st.system_error_report_enable && st.perr_en;
    set_flags[pch_pkg::FLAG_RMA] = events_in.master_abort;
    set_flags[pch_pkg::FLAG_RTA] = events_in.target_abort_rcvd;
    set_flags[pch_pkg::FLAG_STA] = events_in.target_abort_sent;
    set_flags[pch_pkg::FLAG_MDPED] = st.perr_en
        && (events_in.master_data_perr || events_in.master_target_perr);

    next_st.cfg_ack = 1'b0;
    next_st.lcl_ack = 1'b0;
    next_st.cfg_rdata = 32'h0;
    next_st.lcl_rdata = 32'h0;

    // Port 0 is PCI config, port 1 the local bus; local lands last on a clash
    for (int p = 0; p < 2; p++) begin
      if (acc[p].req && acc[p].wr) begin
        case (acc[p].offset)
          pch_pkg::OFF_CMD_STATUS: begin
            if (acc[p].be[0]) begin
              next_st.io_space_enable = acc[p].wdata[pch_pkg::BIT_IOS];
              next_st.ms = acc[p].wdata[pch_pkg::BIT_MS];
              next_st.bm = acc[p].wdata[pch_pkg::BIT_BM];
              next_st.perr_en = acc[p].wdata[pch_pkg::BIT_PARITY_REACTION_ENABLE];
            end
            if (acc[p].be[1]) begin
              next_st.system_error_report_enable = acc[p].wdata[pch_pkg::BIT_SYSTEM_ERROR_REPORT_ENABLE];
            end
            if (acc[p].be[3]) begin
              // Only ones clear; zeros and constant bits are ignored
              clr_flags = clr_flags | {acc[p].wdata[31:27],
                                       acc[p].wdata[pch_pkg::BIT_MDPED]};
            end
          end
          pch_pkg::OFF_CLASS: begin
            if (p == 1 && !eeprom_load_in) begin
              tmp = merge({st.class_code, REVISION}, acc[p].wdata, acc[p].be);
              next_st.class_code = tmp[31:8];
            end
          end
          pch_pkg::OFF_MISC: begin
            if (acc[p].be[1]) begin
              next_st.latency_limit = acc[p].wdata[pch_pkg::LATENCY_LIMIT_LSB +: 7];
            end
            if (acc[p].be[0]) begin
              next_st.cacheline_length = (acc[p].wdata[pch_pkg::CACHELINE_LENGTH_LSB +: 2] == 2'h3)
                  ? pch_pkg::CACHELINE_LENGTH_ZERO : acc[p].wdata[pch_pkg::CACHELINE_LENGTH_LSB +: 2];
            end
          end
          pch_pkg::OFF_BASE_LOW: begin
            if (messaging_unit_enable_in) begin
              tmp = merge({st.msg_base, 12'h0}, acc[p].wdata, acc[p].be);
              next_st.msg_base = tmp[31:pch_pkg::BASE_LSB];
            end else begin
              tmp = merge({st.reg_base, 12'h0}, acc[p].wdata, acc[p].be);
              next_st.reg_base = tmp[31:pch_pkg::BASE_LSB];
              next_st.base_written = 1'b1;
            end
          end
          pch_pkg::OFF_BASE_ALT: begin
            if (messaging_unit_enable_in) begin
              tmp = merge({st.reg_base, 12'h0}, acc[p].wdata, acc[p].be);
              next_st.reg_base = tmp[31:pch_pkg::BASE_LSB];
              next_st.base_written = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (cfg_acc_in.req) begin
      next_st.cfg_ack = 1'b1;
      if (!cfg_acc_in.wr) begin
        next_st.cfg_rdata = read_word(st, cfg_acc_in.offset, messaging_unit_enable_in);
      end
    end
    if (lcl_acc_in.req) begin
      next_st.lcl_ack = 1'b1;
      if (!lcl_acc_in.wr) begin
        next_st.lcl_rdata = read_word(st, lcl_acc_in.offset, messaging_unit_enable_in);
      end
    end

    if (eeprom_load_in) begin
      next_st.class_code = eeprom_class_in;
    end

    // A flag raised in the cycle it is cleared stays set
    next_st.flags = (st.flags & ~clr_flags) | set_flags;
    next_st.status_event = |st.flags;

    next_st.serr = set_flags[pch_pkg::FLAG_SSERR];
    next_st.perr = st.perr_en
        && (events_in.master_data_perr || events_in.target_data_perr);
    next_st.par = ^par_data_in;
    next_st.mwi = dma_cmd_select_in;
    next_st.cl_words = (st.cacheline_length == pch_pkg::CACHELINE_LENGTH_EIGHT)
        ? pch_pkg::WORDS_EIGHT : pch_pkg::WORDS_FOUR;

    // Register decode needs memory space enabled and a base written first
    next_st.reg_hit = addr_valid_in && st.ms && st.base_written
        && (pci_addr_in[31:pch_pkg::BASE_LSB] == st.reg_base);
    next_st.msg_hit = 1'b0;
    next_st.msg_rsvd_hit = 1'b0;
    if (addr_valid_in && st.ms && messaging_unit_enable_in
        && pci_addr_in[31:MSG_WIN_BITS] == st.msg_base[31-pch_pkg::BASE_LSB:
                                                      MSG_WIN_BITS-pch_pkg::BASE_LSB]) begin
      next_st.msg_hit = |pci_addr_in[MSG_WIN_BITS-1:pch_pkg::BASE_LSB];
      next_st.msg_rsvd_hit = ~|pci_addr_in[MSG_WIN_BITS-1:pch_pkg::BASE_LSB];
    end

    if (rst) begin
      // Messaging base deliberately keeps its contents through reset
      next_st.flags = '0;
      next_st.system_error_report_enable = 1'b0;
      next_st.perr_en = 1'b0;
      next_st.bm = st.strap_sync[1];
      next_st.ms = 1'b0;
      next_st.io_space_enable = 1'b0;
      next_st.class_code = pch_pkg::CLASS_RESET;
      next_st.latency_limit = pch_pkg::LATENCY_LIMIT_RESET;
      next_st.cacheline_length = pch_pkg::CACHELINE_LENGTH_ZERO;
      next_st.reg_base = '0;
      next_st.base_written = 1'b0;
      next_st.cfg_ack = 1'b0;
      next_st.cfg_rdata = 32'h0;
      next_st.lcl_ack = 1'b0;
      next_st.lcl_rdata = 32'h0;
      next_st.serr = 1'b0;
      next_st.perr = 1'b0;
      next_st.par = 1'b0;
      next_st.mwi = 1'b0;
      next_st.cl_words = pch_pkg::WORDS_FOUR;
      next_st.reg_hit = 1'b0;
      next_st.msg_hit = 1'b0;
      next_st.msg_rsvd_hit = 1'b0;
      next_st.status_event = 1'b0;
    end
    if (reset_in) begin
      next_st.pci_rst_sync = 2'h0;
      next_st.health_sync = 2'h0;
      // Strap chain keeps running so the option is settled when reset ends
    end
  end

  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign cfg_ack_out = st.cfg_ack;
  assign cfg_rdata_out = st.cfg_rdata;
  assign lcl_ack_out = st.lcl_ack;
  assign lcl_rdata_out = st.lcl_rdata;
  assign serr_out = st.serr;
  assign perr_out = st.perr;
  assign par_out = st.par;
  assign status_event_out = st.status_event;
  assign memory_space_enable_out = st.ms;
  assign io_space_enable_out = st.io_space_enable;
  assign initiator_enable_out = st.bm;
  assign mwi_command_out = st.mwi;
  assign cacheline_words_out = st.cl_words;
  assign latency_limit_out = st.latency_limit;
  assign reg_space_hit_out = st.reg_hit;
  assign msg_window_hit_out = st.msg_hit;
  assign msg_reserved_hit_out = st.msg_rsvd_hit;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst);

  a_dpe_sets: assert property (events_in.target_addr_perr |=> st.flags[pch_pkg::FLAG_DPE])
    else $error("detected parity flag not set");
  a_serr_flag: assert property (serr_out |-> st.flags[pch_pkg::FLAG_SSERR])
    else $error("SERR pulse without its flag");
  a_rma_sets: assert property (events_in.master_abort |=> st.flags[pch_pkg::FLAG_RMA])
    else $error("master abort flag not set");
  a_sta_sets: assert property (events_in.target_abort_sent |=> st.flags[pch_pkg::FLAG_STA])
    else $error("signalled target abort flag not set");
  a_devsel_const: assert property (cfg_ack_out && $past(!cfg_acc_in.wr)
      && $past(cfg_acc_in.offset) == pch_pkg::OFF_CMD_STATUS
      |-> cfg_rdata_out[pch_pkg::BIT_DEVSEL_LO +: 2] == pch_pkg::DEVSEL_MEDIUM)
    else $error("device select timing not 01");
  a_mdped_sets: assert property (events_in.master_target_perr && st.perr_en
      |=> st.flags[pch_pkg::FLAG_MDPED])
    else $error("master data parity flag not set");
  a_perr_gated: assert property (perr_out |-> $past(st.perr_en))
    else $error("PERR pulse with parity response off");
  a_perr_raised: assert property (events_in.target_data_perr && st.perr_en
      |=> perr_out)
    else $error("PERR pulse missing on data parity error");
  a_serr_gated: assert property (serr_out |-> $past(st.system_error_report_enable) && $past(st.perr_en))
    else $error("SERR pulse without both enables");
  a_cacheline_length_legal: assert property (st.cacheline_length != 2'h3 && cacheline_words_out != 4'h0)
    else $error("illegal cache line value held");
  a_latency_limit_reset: assert property (disable iff (reset_in)
      $past(rst) |-> st.latency_limit == pch_pkg::LATENCY_LIMIT_RESET)
    else $error("latency timer reset value wrong");
  a_class_lock: assert property (cfg_acc_in.req && cfg_acc_in.wr
      && cfg_acc_in.offset == pch_pkg::OFF_CLASS && !lcl_acc_in.req && !eeprom_load_in
      |=> $stable(st.class_code))
    else $error("PCI write changed class code");
  a_reg_hit: assert property (reg_space_hit_out
      |-> $past(pci_addr_in[31:pch_pkg::BASE_LSB]) == $past(st.reg_base) && $past(st.ms))
    else $error("register hit on wrong address");

  c_serr: cover property (events_in.target_addr_perr ##1 serr_out);
  c_reg_hit: cover property (reg_space_hit_out);
  c_msg_hit: cover property (msg_window_hit_out ##[1:3] msg_reserved_hit_out);

endmodule : pch_config_header

// ### rtl/pch_pkg.sv
package pch_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CMD_STATUS = 12'h004;
  localparam logic [11:0] OFF_CLASS = 12'h008;
  localparam logic [11:0] OFF_MISC = 12'h00c;
  localparam logic [11:0] OFF_BASE_LOW = 12'h010;
  localparam logic [11:0] OFF_BASE_ALT = 12'h018;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FLAG_DPE = 5;
  localparam int FLAG_SSERR = 4;
  localparam int FLAG_RMA = 3;
  localparam int FLAG_RTA = 2;
  localparam int FLAG_STA = 1;
  localparam int FLAG_MDPED = 0;
  localparam int NUM_FLAGS = 6;
  localparam int BIT_IOS = 0;
  localparam int BIT_MS = 1;
  localparam int BIT_BM = 2;
  localparam int BIT_PARITY_REACTION_ENABLE = 6;
  localparam int BIT_SYSTEM_ERROR_REPORT_ENABLE = 8;
  localparam int BIT_DEVSEL_LO = 25;
  localparam int BIT_TARGET_BACK_TO_BACK_FLAG = 23;
  localparam int BIT_CAPABILITY_LIST_FLAG = 20;
  localparam int BIT_MDPED = 24;
  localparam int BASE_LSB = 12;
  localparam int LATENCY_LIMIT_LSB = 9;
  localparam int CACHELINE_LENGTH_LSB = 2;

  // ---------------------------------------------------------------
  // Reset and constant values
  // ---------------------------------------------------------------
  localparam logic [23:0] CLASS_RESET = 24'h068000;
  localparam logic [6:0] LATENCY_LIMIT_RESET = 7'h04;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic [1:0] CACHELINE_LENGTH_FOUR = 2'h1;
  localparam logic [1:0] CACHELINE_LENGTH_EIGHT = 2'h2;
  localparam logic [1:0] CACHELINE_LENGTH_ZERO = 2'h0;
  localparam logic [3:0] WORDS_FOUR = 4'h4;
  localparam logic [3:0] WORDS_EIGHT = 4'h8;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic wr;
    logic [11:0] offset;
    logic [31:0] wdata;
    logic [3:0] be;
  } pch_access_t;

  typedef struct packed {
    logic master_data_perr;
    logic target_addr_perr;
    logic target_data_perr;
    logic master_abort;
    logic target_abort_rcvd;
    logic target_abort_sent;
    logic master_target_perr;
  } pch_events_t;

  typedef struct packed {
    logic [1:0] pci_rst_sync;
    logic [1:0] health_sync;
    logic [1:0] strap_sync;
    logic [NUM_FLAGS-1:0] flags;
    logic system_error_report_enable;
    logic perr_en;
    logic bm;
    logic ms;
    logic io_space_enable;
    logic [23:0] class_code;
    logic [6:0] latency_limit;
    logic [1:0] cacheline_length;
    logic [19:0] reg_base;
    logic base_written;
    logic [19:0] msg_base;
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic lcl_ack;
    logic [31:0] lcl_rdata;
    logic serr;
    logic perr;
    logic par;
    logic mwi;
    logic [3:0] cl_words;
    logic reg_hit;
    logic msg_hit;
    logic msg_rsvd_hit;
    logic status_event;
  } pch_state_t;

endpackage : pch_pkg

// ### test/pch_host_model.sv
module pch_host_model (
  input wire logic clk_in,  // Bus clock
  output pch_pkg::pch_access_t acc_out,  // Config access
  output pch_pkg::pch_events_t ev_out  // Bus event pulses
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    acc_out = '0;
    ev_out = '0;
  end

  // ---------------------------------------------------------------
  // Config cycles
  // ---------------------------------------------------------------
  // Released data is inverted so a stale value never looks valid
  task automatic cfg(input logic w, input logic [11:0] off, input logic [31:0] d);
    @(posedge clk_in);
    acc_out <= '{req: 1'b1, wr: w, offset: off, wdata: d, be: 4'hf};
    @(posedge clk_in);
    acc_out.req <= 1'b0;
    acc_out.wdata <= ~d;
  endtask : cfg

  // One-cycle bus event, bit index in the event carrier
  task automatic pulse(input int idx);
    @(posedge clk_in);
    ev_out <= pch_pkg::pch_events_t'(7'h01 << idx);
    @(posedge clk_in);
    ev_out <= '0;
  endtask : pulse
endmodule : pch_host_model

// ### test/tb_pci_config_header.sv
module tb_pci_config_header;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] REV = 8'h3c;  // Arbitrary value
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic pci_rst_n_in = 1'b1;
  logic health_in = 1'b0;
  logic eeprom_load = 1'b0;
  logic [23:0] eeprom_class = 24'h000000;
  logic msg_en = 1'b0;
  logic dma_sel = 1'b0;
  logic addr_valid = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [35:0] par_data = 36'h0;
  pch_pkg::pch_access_t cfg_acc;
  pch_pkg::pch_access_t lcl_acc = '0;
  pch_pkg::pch_events_t ev;
  logic cfg_ack, lcl_ack, serr, perr, par, stat_ev, mem_en, io_en, bm_en, mwi;
  logic reg_hit, msg_hit, rsv_hit;
  logic [31:0] cfg_rdata, lcl_rdata;
  logic [3:0] cl_words;
  logic [6:0] lat;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] cfg_q[$];
  logic [31:0] lcl_q[$];
  logic [7:0] flag_tab[7] = '{8'h01, 8'h08, 8'h10, 8'h20, 8'h80, 8'hc0, 8'h81};

  always #20 core_clk_in = ~core_clk_in;

  pch_host_model host (.clk_in(core_clk_in), .acc_out(cfg_acc), .ev_out(ev));

  pch_config_header #(.REVISION(REV)) uut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .pci_rst_n_in(pci_rst_n_in),
    .board_health_input_in(health_in), .initiator_strap_in(1'b1),
    .cfg_acc_in(cfg_acc), .lcl_acc_in(lcl_acc), .events_in(ev),
    .eeprom_load_in(eeprom_load), .eeprom_class_in(eeprom_class),
    .messaging_unit_enable_in(msg_en), .dma_cmd_select_in(dma_sel),
    .addr_valid_in(addr_valid), .pci_addr_in(addr), .par_data_in(par_data),
    .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .lcl_ack_out(lcl_ack),
    .lcl_rdata_out(lcl_rdata), .serr_out(serr), .perr_out(perr), .par_out(par),
    .status_event_out(stat_ev), .memory_space_enable_out(mem_en),
    .io_space_enable_out(io_en), .initiator_enable_out(bm_en), .mwi_command_out(mwi),
    .cacheline_words_out(cl_words), .latency_limit_out(lat),
    .reg_space_hit_out(reg_hit), .msg_window_hit_out(msg_hit),
    .msg_reserved_hit_out(rsv_hit));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ---------------------------------------------------------------
  // Answer monitor, oldest note first
  // ---------------------------------------------------------------
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      n_fail++;
      print_verdict();
    end
    if (cfg_ack === 1'b1) chk("cfg_rdata", cfg_q.pop_front(), cfg_rdata);
    if (lcl_ack === 1'b1) chk("lcl_rdata", lcl_q.pop_front(), lcl_rdata);
  end

  task automatic rd(input logic [11:0] off, input logic [31:0] exp);
    cfg_q.push_back(exp);
    host.cfg(1'b0, off, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] off, input logic [31:0] d);
    cfg_q.push_back(32'h0);
    host.cfg(1'b1, off, d);
  endtask : wr

  task automatic lacc(input logic w, input logic [11:0] off, input logic [31:0] d,
                      input logic [31:0] exp);
    lcl_q.push_back(exp);
    @(posedge core_clk_in);
    lcl_acc <= '{req: 1'b1, wr: w, offset: off, wdata: d, be: 4'hf};
    @(posedge core_clk_in);
    lcl_acc.req <= 1'b0;
  endtask : lacc

  task automatic dec(input logic [31:0] a, input logic [2:0] exp);
    @(posedge core_clk_in);
    addr_valid <= 1'b1;
    addr <= a;
    @(posedge core_clk_in);
    addr_valid <= 1'b0;
    #1 chk("hits", 32'(exp), 32'({reg_hit, msg_hit, rsv_hit}));
  endtask : dec

  initial begin
    logic [31:0] v;
    logic [6:0] lt;
    void'($urandom(5));
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rd(pch_pkg::OFF_CMD_STATUS, 32'h0290_0004);
    rd(pch_pkg::OFF_CLASS, {24'h068000, REV});
    rd(pch_pkg::OFF_MISC, 32'h0000_0800);
    rd(pch_pkg::OFF_BASE_ALT, 32'h0);
    chk("rst_out", 32'({cl_words, lat, mem_en, io_en, bm_en}), 32'h1021);
    wr(pch_pkg::OFF_CMD_STATUS, 32'hffff_ffff);
    rd(pch_pkg::OFF_CMD_STATUS, 32'h0290_0147);
    chk("enables", 32'({mem_en, io_en, bm_en}), 32'h7);
    // ---------------------------------------------------------------
    // Each bus event, then write-zero and write-one on the flags
    // ---------------------------------------------------------------
    for (int i = 0; i < 7; i++) begin
      host.pulse(i);
      #1 chk("serr", 32'(i == 5), 32'(serr));
      chk("perr", 32'(i == 4 || i == 6), 32'(perr));
      @(posedge core_clk_in);
      #1 chk("event", 32'h1, 32'(stat_ev));
      rd(pch_pkg::OFF_CMD_STATUS, {flag_tab[i] | 8'h02, 24'h900147});
      wr(pch_pkg::OFF_CMD_STATUS, 32'h0000_0147);
      rd(pch_pkg::OFF_CMD_STATUS, {flag_tab[i] | 8'h02, 24'h900147});
      wr(pch_pkg::OFF_CMD_STATUS, 32'hff00_0147);
      rd(pch_pkg::OFF_CMD_STATUS, 32'h0290_0147);
    end
    wr(pch_pkg::OFF_CMD_STATUS, 32'h0000_0100);
    host.pulse(5);
    #1 chk("serr", 32'h0, 32'(serr));
    host.pulse(4);
    #1 chk("perr", 32'h0, 32'(perr));
    rd(pch_pkg::OFF_CMD_STATUS, 32'h8290_0100);
    repeat (4) begin
      v = $urandom();
      @(posedge core_clk_in);
      par_data <= {v[3:0], v};
      dma_sel <= v[5];
      @(posedge core_clk_in);
      #1 chk("par", 32'(^{v[3:0], v}), 32'(par));
      chk("mwi", 32'(v[5]), 32'(mwi));
    end
    wr(pch_pkg::OFF_CMD_STATUS, 32'h8000_0146);
    for (int c = 0; c < 4; c++) begin
      lt = 7'($urandom());
      wr(pch_pkg::OFF_MISC, {16'hffff, lt, 1'b1, 4'hf, c[1:0], 2'b11});
      rd(pch_pkg::OFF_MISC, {16'h0, lt, 5'h0, (c == 3) ? 2'b00 : c[1:0], 2'b00});
      chk("words", (c == 2) ? 32'h8 : 32'h4, 32'(cl_words));
      chk("latency", 32'(lt), 32'(lat));
    end
    // Class word only moves from the local side or the EEPROM
    wr(pch_pkg::OFF_CLASS, 32'hffff_ffff);
    rd(pch_pkg::OFF_CLASS, {24'h068000, REV});
    lacc(1'b1, pch_pkg::OFF_CLASS, 32'h0e0001ff, 32'h0);
    lacc(1'b0, pch_pkg::OFF_CLASS, 32'h0, {24'h0e0001, REV});
    v = $urandom();
    @(posedge core_clk_in);
    eeprom_class <= v[23:0];
    eeprom_load <= 1'b1;
    @(posedge core_clk_in);
    eeprom_load <= 1'b0;
    rd(pch_pkg::OFF_CLASS, {v[23:0], REV});
    v = $urandom();
    wr(pch_pkg::OFF_BASE_LOW, v);
    rd(pch_pkg::OFF_BASE_LOW, {v[31:12], 12'h000});
    dec({v[31:12], 12'h5a4}, 3'b100);
    dec({~v[31], v[30:12], 12'h000}, 3'b000);
    @(posedge core_clk_in);
    msg_en <= 1'b1;
    wr(pch_pkg::OFF_BASE_LOW, 32'h1234_5678);
    rd(pch_pkg::OFF_BASE_ALT, {v[31:12], 12'h000});
    rd(pch_pkg::OFF_BASE_LOW, 32'h1234_5000);
    dec(32'h1234_8000, 3'b010);
    dec(32'h1234_0abc, 3'b001);
    // Pin reset first, then board health
    for (int k = 0; k < 2; k++) begin
      wr(pch_pkg::OFF_MISC, 32'h0000_fe04);
      @(posedge core_clk_in);
      pci_rst_n_in <= k[0];
      health_in <= k[0];
      repeat (4) @(posedge core_clk_in);
      pci_rst_n_in <= 1'b1;
      health_in <= 1'b0;
      repeat (5) @(posedge core_clk_in);
      rd(pch_pkg::OFF_MISC, 32'h0000_0800);
      rd(pch_pkg::OFF_BASE_ALT, 32'h0);
      rd(pch_pkg::OFF_CMD_STATUS, 32'h0290_0004);
    end
    rd(pch_pkg::OFF_BASE_LOW, 32'h1234_5000);
    repeat (3) @(posedge core_clk_in);
    print_verdict();
  end
endmodule : tb_pci_config_header
